// ==== tex_pkg.sv ====
// Constants, field positions and types for the trap / enable-write / XOR execute unit
//
// Behaviour
// - Immediate trap compares target-field register with sign-extended immediate
// - Condition field codes select signed and logical compares
// - Trap debug off gives program interrupt, vector 0x0700
// - External trap debug enters stop, sets trap event
// - Plus internal, exceptions off: imprecise flag, reload address
// - Internal only, exceptions on: debug interrupt via pair two
// - Internal only, exceptions off: program interrupt plus flags
// - Register enable write copies source bit 15
// - Immediate enable write copies its one-bit field
// - Enable writes ignored in problem state
// - Record bit on enable writes leaves field zero
// - Register XOR writes target, record updates field zero
// - Low immediate XOR zero-extends left, condition untouched
// - Shifted immediate XOR pads right, condition untouched
// - Thirty-two general registers, numbered 0 to 31
package tex_pkg;

  localparam int XLEN = 32;
  localparam int NUM_GEN_REG = 32;
  localparam int ADDR_W = 7;

  // -------------------------------------------------------------
  // Instruction encoding
  // -------------------------------------------------------------
  localparam logic [5:0] OP_TRAP_IMM = 6'h03;
  localparam logic [5:0] OP_XOR_LOW = 6'h1A;
  localparam logic [5:0] OP_XOR_SHIFT = 6'h1B;
  localparam logic [5:0] OP_EXTENDED = 6'h1F;
  localparam logic [9:0] XO_XOR = 10'h13C;
  localparam logic [9:0] XO_IEN_REG = 10'h083;
  localparam logic [9:0] XO_IEN_IMM = 10'h0A3;

  // Condition field bit indices (bit 4 is the first, leftmost bit)
  localparam int COND_LT = 4;
  localparam int COND_GT = 3;
  localparam int COND_EQ = 2;
  localparam int COND_LLT = 1;
  localparam int COND_LGT = 0;

  // -------------------------------------------------------------
  // Register field positions (bit 0 is the least significant)
  // -------------------------------------------------------------
  localparam int MS_WAIT = 18;
  localparam int MS_CRIT_EN = 17;
  localparam int MS_EXT_EN = 15;
  localparam int MS_PROBLEM = 14;
  localparam int MS_DBG_EN = 9;
  localparam int MS_ITRANS = 5;
  localparam int MS_DTRANS = 4;
  localparam int SRC_IEN_BIT = 15;
  localparam int IMM_IEN_BIT = 15;
  localparam int DC_TRAP_EN = 0;
  localparam int DC_EXT_MODE = 1;
  localparam int DC_INT_MODE = 2;
  localparam int DS_TRAP_EVT = 0;
  localparam int DS_IMPRECISE = 1;
  localparam int SYN_PROG_TRAP = 0;
  localparam int FX_SUM_OVF = 0;
  localparam int CF_LT = 3;
  localparam int CF_GT = 2;
  localparam int CF_EQ = 1;
  localparam int CF_SO = 0;
  localparam int CTL_STOPPED = 0;

  localparam logic [15:0] VEC_PROGRAM = 16'h0700;
  localparam logic [15:0] VEC_DEBUG = 16'h2000;
  localparam logic [31:0] RST_WORD = 32'h00000000;

  // -------------------------------------------------------------
  // Word addresses on the register bus
  // -------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_MACHINE_STATE = 7'h20;
  localparam logic [ADDR_W-1:0] ADDR_DEBUG_CONTROL = 7'h21;
  localparam logic [ADDR_W-1:0] ADDR_DEBUG_STATUS = 7'h22;
  localparam logic [ADDR_W-1:0] ADDR_SYNDROME = 7'h23;
  localparam logic [ADDR_W-1:0] ADDR_VECTOR_PREFIX = 7'h24;
  localparam logic [ADDR_W-1:0] ADDR_SAVE_ZERO = 7'h25;
  localparam logic [ADDR_W-1:0] ADDR_SAVE_ONE = 7'h26;
  localparam logic [ADDR_W-1:0] ADDR_SAVE_TWO = 7'h27;
  localparam logic [ADDR_W-1:0] ADDR_SAVE_THREE = 7'h28;
  localparam logic [ADDR_W-1:0] ADDR_FIXED_EXC = 7'h29;
  localparam logic [ADDR_W-1:0] ADDR_COND = 7'h2A;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 7'h2B;

  typedef enum logic [0:0] {TEX_RUN, TEX_STOP} tex_mode_e;

endpackage

// ==== tex_exec.sv ====
// Execute unit for immediate trap, enable writes and XOR, with register bus
`timescale 1ns/1ps
module tex_exec
  import tex_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Instruction issue
  input wire logic INSTR_VALID,
  output logic INSTR_READY,
  input wire logic [31:0] INSTR_WORD,
  input wire logic [31:0] INSTR_ADDR,
  // Execution result
  output logic INSTR_DONE,
  output logic PC_LOAD,
  output logic [31:0] PC_TARGET,
  output logic DEBUG_STOP,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);

  typedef struct packed {
    tex_mode_e mode;
    logic [NUM_GEN_REG-1:0][31:0] gen_reg;
    logic [31:0] machine_state_reg;
    logic [31:0] debug_control_reg;
    logic [31:0] debug_status_reg;
    logic [31:0] exception_syndrome_reg;
    logic [31:0] vector_prefix_reg;
    logic [31:0] save_restore_zero;
    logic [31:0] save_restore_one;
    logic [31:0] save_restore_two;
    logic [31:0] save_restore_three;
    logic [31:0] fixed_exc_reg;
    logic [31:0] cond_reg;
    logic [31:0] pc_target;
    logic pc_load;
    logic done;
    logic ack;
    logic [31:0] rdata;
  } tex_state_s;

  tex_state_s st_r;
  tex_state_s st_nxt;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // -------------------------------------------------------------
  // Instruction decode
  // -------------------------------------------------------------
  logic exec;
  logic [5:0] opcode;
  logic [9:0] ext_op;
  logic [4:0] src_idx;
  logic [4:0] tgt_idx;
  logic [4:0] src2_idx;
  logic [4:0] trap_condition_field;
  logic [15:0] immediate_field;
  logic record_bit;
  logic [31:0] src_val;
  logic [31:0] tgt_val;
  logic [31:0] src2_val;
  logic [31:0] imm_sext;
  logic is_trap;
  logic is_xor;
  logic is_xor_low;
  logic is_xor_shift;
  logic is_ien_reg;
  logic is_ien_imm;
  logic trap_take;
  logic trap_debug_enable;
  logic external_debug_mode;
  logic internal_debug_mode;
  logic debug_exception_enable;
  logic problem_state_bit;
  logic rt_prog;
  logic rt_ext;
  logic rt_dint;
  logic rt_dprog;
  logic [31:0] xor_res;
  logic bus_wr;

  assign INSTR_READY = (st_r.mode == TEX_RUN);
  assign exec = INSTR_VALID && INSTR_READY;
  assign opcode = INSTR_WORD[31:26];
  assign ext_op = INSTR_WORD[10:1];
  assign src_idx = INSTR_WORD[25:21];
  assign trap_condition_field = INSTR_WORD[25:21];
  assign tgt_idx = INSTR_WORD[20:16];
  assign src2_idx = INSTR_WORD[15:11];
  assign immediate_field = INSTR_WORD[15:0];
  assign record_bit = INSTR_WORD[0];
  assign src_val = st_r.gen_reg[src_idx];
  assign tgt_val = st_r.gen_reg[tgt_idx];
  assign src2_val = st_r.gen_reg[src2_idx];
  assign imm_sext = {{16{immediate_field[15]}}, immediate_field};

  assign is_trap = exec && (opcode == OP_TRAP_IMM);
  assign is_xor_low = exec && (opcode == OP_XOR_LOW);
  assign is_xor_shift = exec && (opcode == OP_XOR_SHIFT);
  assign is_xor = exec && (opcode == OP_EXTENDED) && (ext_op == XO_XOR);
  assign is_ien_reg = exec && (opcode == OP_EXTENDED) && (ext_op == XO_IEN_REG);
  assign is_ien_imm = exec && (opcode == OP_EXTENDED) && (ext_op == XO_IEN_IMM);

  // Trap compare; the target-field register is the compared one
  assign trap_take = is_trap && (
    (trap_condition_field[COND_LT] && ($signed(tgt_val) < $signed(imm_sext))) ||
    (trap_condition_field[COND_GT] && ($signed(tgt_val) > $signed(imm_sext))) ||
    (trap_condition_field[COND_EQ] && (tgt_val == imm_sext)) ||
    (trap_condition_field[COND_LLT] && (tgt_val < imm_sext)) ||
    (trap_condition_field[COND_LGT] && (tgt_val > imm_sext)));

  assign trap_debug_enable = st_r.debug_control_reg[DC_TRAP_EN];
  assign external_debug_mode = st_r.debug_control_reg[DC_EXT_MODE];
  assign internal_debug_mode = st_r.debug_control_reg[DC_INT_MODE];
  assign debug_exception_enable = st_r.machine_state_reg[MS_DBG_EN];
  assign problem_state_bit = st_r.machine_state_reg[MS_PROBLEM];

  assign rt_prog = trap_take && (!trap_debug_enable ||
                   (!external_debug_mode && !internal_debug_mode));
  assign rt_ext = trap_take && trap_debug_enable && external_debug_mode;
  assign rt_dint = trap_take && trap_debug_enable && !external_debug_mode &&
                   internal_debug_mode && debug_exception_enable;
  assign rt_dprog = trap_take && trap_debug_enable && !external_debug_mode &&
                    internal_debug_mode && !debug_exception_enable;

  always_comb begin
    if (is_xor_low) begin
      xor_res = src_val ^ {16'h0000, immediate_field};
    end else if (is_xor_shift) begin
      xor_res = src_val ^ {immediate_field, 16'h0000};
    end else begin
      xor_res = src_val ^ src2_val;
    end
  end

  assign bus_wr = AVS_WRITE && st_r.ack;

  // -------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.pc_load = 1'b0;
    st_nxt.done = exec;
    // One wait cycle per access; read data captured during it
    st_nxt.ack = (AVS_READ || AVS_WRITE) && !st_r.ack;
    if (AVS_READ && !st_r.ack) begin
      if (AVS_ADDRESS[ADDR_W-1:5] == 2'b00) begin
        st_nxt.rdata = st_r.gen_reg[AVS_ADDRESS[4:0]];
      end else begin
        unique case (AVS_ADDRESS)
          ADDR_MACHINE_STATE: st_nxt.rdata = st_r.machine_state_reg;
          ADDR_DEBUG_CONTROL: st_nxt.rdata = st_r.debug_control_reg;
          ADDR_DEBUG_STATUS: st_nxt.rdata = st_r.debug_status_reg;
          ADDR_SYNDROME: st_nxt.rdata = st_r.exception_syndrome_reg;
          ADDR_VECTOR_PREFIX: st_nxt.rdata = st_r.vector_prefix_reg;
          ADDR_SAVE_ZERO: st_nxt.rdata = st_r.save_restore_zero;
          ADDR_SAVE_ONE: st_nxt.rdata = st_r.save_restore_one;
          ADDR_SAVE_TWO: st_nxt.rdata = st_r.save_restore_two;
          ADDR_SAVE_THREE: st_nxt.rdata = st_r.save_restore_three;
          ADDR_FIXED_EXC: st_nxt.rdata = st_r.fixed_exc_reg;
          ADDR_COND: st_nxt.rdata = st_r.cond_reg;
          ADDR_CONTROL: st_nxt.rdata = {31'h00000000, st_r.mode == TEX_STOP};
          default: st_nxt.rdata = RST_WORD;
        endcase
      end
    end
    // Bus writes first, so an instruction in the same cycle overrides them
    if (bus_wr) begin
      if (AVS_ADDRESS[ADDR_W-1:5] == 2'b00) begin
        st_nxt.gen_reg[AVS_ADDRESS[4:0]] =
          be_merge(st_r.gen_reg[AVS_ADDRESS[4:0]], AVS_WRITEDATA, AVS_BYTEENABLE);
      end else begin
        unique case (AVS_ADDRESS)
          ADDR_MACHINE_STATE: st_nxt.machine_state_reg =
            be_merge(st_r.machine_state_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
          ADDR_DEBUG_CONTROL: st_nxt.debug_control_reg =
            be_merge(st_r.debug_control_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
          // Write one to clear
          ADDR_DEBUG_STATUS: st_nxt.debug_status_reg =
            st_r.debug_status_reg & ~be_merge(RST_WORD, AVS_WRITEDATA, AVS_BYTEENABLE);
          ADDR_SYNDROME: st_nxt.exception_syndrome_reg =
            be_merge(st_r.exception_syndrome_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
          ADDR_VECTOR_PREFIX: st_nxt.vector_prefix_reg =
            be_merge(st_r.vector_prefix_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
          ADDR_SAVE_ZERO: st_nxt.save_restore_zero =
            be_merge(st_r.save_restore_zero, AVS_WRITEDATA, AVS_BYTEENABLE);
          ADDR_SAVE_ONE: st_nxt.save_restore_one =
            be_merge(st_r.save_restore_one, AVS_WRITEDATA, AVS_BYTEENABLE);
          ADDR_SAVE_TWO: st_nxt.save_restore_two =
            be_merge(st_r.save_restore_two, AVS_WRITEDATA, AVS_BYTEENABLE);
          ADDR_SAVE_THREE: st_nxt.save_restore_three =
            be_merge(st_r.save_restore_three, AVS_WRITEDATA, AVS_BYTEENABLE);
          ADDR_FIXED_EXC: st_nxt.fixed_exc_reg =
            be_merge(st_r.fixed_exc_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
          ADDR_COND: st_nxt.cond_reg =
            be_merge(st_r.cond_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
          ADDR_CONTROL: begin
            // Debugger releases the stop state
            if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[CTL_STOPPED]) begin
              st_nxt.mode = TEX_RUN;
            end
          end
          default: begin
          end
        endcase
      end
    end
    // Instruction effects
    if (is_xor || is_xor_low || is_xor_shift) begin
      st_nxt.gen_reg[tgt_idx] = xor_res;
      if (is_xor && record_bit) begin
        st_nxt.cond_reg[CF_LT] = xor_res[31];
        st_nxt.cond_reg[CF_GT] = !xor_res[31] && (xor_res != RST_WORD);
        st_nxt.cond_reg[CF_EQ] = (xor_res == RST_WORD);
        st_nxt.cond_reg[CF_SO] = st_r.fixed_exc_reg[FX_SUM_OVF];
      end
    end
    // Condition field is left alone whatever the record bit says
    if (is_ien_reg && !problem_state_bit) begin
      st_nxt.machine_state_reg[MS_EXT_EN] = src_val[SRC_IEN_BIT];
    end
    if (is_ien_imm && !problem_state_bit) begin
      st_nxt.machine_state_reg[MS_EXT_EN] = INSTR_WORD[IMM_IEN_BIT];
    end
    if (rt_prog || rt_dprog) begin
      st_nxt.save_restore_zero = INSTR_ADDR;
      st_nxt.save_restore_one = st_r.machine_state_reg;
      st_nxt.exception_syndrome_reg[SYN_PROG_TRAP] = 1'b1;
      st_nxt.machine_state_reg[MS_WAIT] = 1'b0;
      st_nxt.machine_state_reg[MS_EXT_EN] = 1'b0;
      st_nxt.machine_state_reg[MS_PROBLEM] = 1'b0;
      st_nxt.machine_state_reg[MS_DTRANS] = 1'b0;
      st_nxt.machine_state_reg[MS_ITRANS] = 1'b0;
      st_nxt.pc_target = {st_r.vector_prefix_reg[31:16], VEC_PROGRAM};
      st_nxt.pc_load = 1'b1;
    end
    if (rt_dprog) begin
      // Status set after the bus clear above, so the event wins
      st_nxt.debug_status_reg[DS_TRAP_EVT] = 1'b1;
      st_nxt.debug_status_reg[DS_IMPRECISE] = 1'b1;
    end
    if (rt_ext) begin
      st_nxt.mode = TEX_STOP;
      st_nxt.debug_status_reg[DS_TRAP_EVT] = 1'b1;
      if (internal_debug_mode && !debug_exception_enable) begin
        st_nxt.debug_status_reg[DS_IMPRECISE] = 1'b1;
        st_nxt.pc_target = INSTR_ADDR;
        st_nxt.pc_load = 1'b1;
      end
    end
    if (rt_dint) begin
      st_nxt.save_restore_two = INSTR_ADDR;
      st_nxt.save_restore_three = st_r.machine_state_reg;
      st_nxt.debug_status_reg[DS_TRAP_EVT] = 1'b1;
      st_nxt.machine_state_reg[MS_WAIT] = 1'b0;
      st_nxt.machine_state_reg[MS_EXT_EN] = 1'b0;
      st_nxt.machine_state_reg[MS_PROBLEM] = 1'b0;
      st_nxt.machine_state_reg[MS_CRIT_EN] = 1'b0;
      st_nxt.machine_state_reg[MS_DBG_EN] = 1'b0;
      st_nxt.machine_state_reg[MS_DTRANS] = 1'b0;
      st_nxt.machine_state_reg[MS_ITRANS] = 1'b0;
      st_nxt.pc_target = {st_r.vector_prefix_reg[31:16], VEC_DEBUG};
      st_nxt.pc_load = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign INSTR_DONE = st_r.done;
  assign PC_LOAD = st_r.pc_load;
  assign PC_TARGET = st_r.pc_target;
  assign DEBUG_STOP = (st_r.mode == TEX_STOP);
  assign AVS_READDATA = st_r.rdata;
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !st_r.ack;

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_ext_trap;
    rt_ext && internal_debug_mode && !debug_exception_enable;
  endsequence

  sequence s_stop_held;
    DEBUG_STOP && !INSTR_READY;
  endsequence

  prog_vector_a: assert property (rt_prog |=> PC_LOAD &&
    PC_TARGET == {$past(st_r.vector_prefix_reg[31:16]), VEC_PROGRAM})
    else $error("program trap vector wrong");
  ext_stop_a: assert property (rt_ext |=> s_stop_held ##0
    st_r.debug_status_reg[DS_TRAP_EVT])
    else $error("external trap did not stop");
  imprecise_pc_a: assert property (s_ext_trap |=> PC_LOAD &&
    PC_TARGET == $past(INSTR_ADDR) && st_r.debug_status_reg[DS_IMPRECISE])
    else $error("imprecise trap handling wrong");
  debug_int_a: assert property (rt_dint |=> st_r.save_restore_two == $past(INSTR_ADDR) &&
    !st_r.machine_state_reg[MS_DBG_EN] &&
    PC_TARGET == {$past(st_r.vector_prefix_reg[31:16]), VEC_DEBUG})
    else $error("debug interrupt wrong");
  imprecise_prog_a: assert property (rt_dprog |=> st_r.exception_syndrome_reg[SYN_PROG_TRAP] &&
    st_r.debug_status_reg[DS_TRAP_EVT] && st_r.debug_status_reg[DS_IMPRECISE] &&
    st_r.save_restore_one == $past(st_r.machine_state_reg))
    else $error("imprecise program interrupt wrong");
  ien_reg_a: assert property (is_ien_reg && !problem_state_bit |=>
    st_r.machine_state_reg[MS_EXT_EN] == $past(src_val[SRC_IEN_BIT]))
    else $error("register enable write wrong");
  ien_imm_a: assert property (is_ien_imm && !problem_state_bit |=>
    st_r.machine_state_reg[MS_EXT_EN] == $past(INSTR_WORD[IMM_IEN_BIT]))
    else $error("immediate enable write wrong");
  ien_priv_a: assert property ((is_ien_reg || is_ien_imm) && problem_state_bit &&
    !(bus_wr && AVS_ADDRESS == ADDR_MACHINE_STATE) |=> $stable(st_r.machine_state_reg))
    else $error("enable changed in problem state");
  xor_result_a: assert property (is_xor |=>
    st_r.gen_reg[$past(tgt_idx)] == ($past(src_val) ^ $past(src2_val)))
    else $error("xor result wrong");
  xor_imm_cond_a: assert property ((is_xor_low || is_xor_shift) &&
    !(bus_wr && AVS_ADDRESS == ADDR_COND) |=> $stable(st_r.cond_reg))
    else $error("immediate xor altered condition");
  stop_hold_a: assert property ((s_stop_held and
    !(bus_wr && AVS_ADDRESS == ADDR_CONTROL)) |=> s_stop_held)
    else $error("stop state left without release");

endmodule

// ==== trap_ee_xor_exec_tb_top.sv ====
// Self-checking bench for the trap, enable-write and XOR execute unit
`timescale 1ns/1ps
module trap_ee_xor_exec_tb_top import tex_pkg::*;;
  logic ref_clk, rst_n, instr_valid, instr_ready, instr_done, pc_load, debug_stop;
  logic avs_read, avs_write, avs_waitrequest, seen_load, seen_stop;
  logic [31:0] instr_word, instr_addr, pc_target, avs_writedata, avs_readdata, rd, seen_tgt;
  logic [ADDR_W-1:0] avs_address;
  logic [3:0] avs_byteenable;
  int miscompares = 0;
  int cmp_count = 0;
  localparam logic [31:0] TRAP_ALWAYS = {OP_TRAP_IMM, 5'h04, 5'h00, 16'h0000};

  tex_exec DUT (.REF_CLK(ref_clk), .RST_N(rst_n), .INSTR_VALID(instr_valid),
    .INSTR_READY(instr_ready), .INSTR_WORD(instr_word), .INSTR_ADDR(instr_addr),
    .INSTR_DONE(instr_done), .PC_LOAD(pc_load), .PC_TARGET(pc_target),
    .DEBUG_STOP(debug_stop), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest));

  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held until the rising edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'h0 && n < 8) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 8) begin
      miscompares++;
      final_report;
    end
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask

  task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic issue(input logic [31:0] w, input logic [31:0] a);
    @(posedge ref_clk);
    instr_valid <= 1'h1;
    instr_word <= w;
    instr_addr <= a;
    @(negedge ref_clk);
    chk("ready", 32'h1, {31'h0, instr_ready});
    @(posedge ref_clk);
    instr_valid <= 1'h0;
    @(negedge ref_clk);
    chk("done", 32'h1, {31'h0, instr_done});
    seen_load = pc_load;
    seen_tgt = pc_target;
    seen_stop = debug_stop;
  endtask

  task automatic arm(input logic [31:0] st_v, input logic [31:0] dctl, input logic [31:0] a);
    bus(1'h1, ADDR_MACHINE_STATE, st_v);
    bus(1'h1, ADDR_DEBUG_CONTROL, dctl);
    bus(1'h1, ADDR_DEBUG_STATUS, 32'h3);
    bus(1'h1, ADDR_SYNDROME, 32'h0);
    issue(TRAP_ALWAYS, a);
  endtask

  task automatic trap_case(input logic [4:0] cnd, input logic [31:0] reg_v,
                           input logic [15:0] imm_v, input logic exp);
    bus(1'h1, 7'h05, reg_v);
    issue({OP_TRAP_IMM, cnd, 5'h05, imm_v}, 32'h0000_1000);
    chk("trap taken", {31'h0, exp}, {31'h0, seen_load});
    if (exp) chk("trap vector", 32'hABCD_0700, seen_tgt);
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic test_regs;
    rdchk("state reset", ADDR_MACHINE_STATE, 32'h0);
    bus(1'h1, 7'h1F, 32'hA5A5_5A5A);
    rdchk("gen reg 31", 7'h1F, 32'hA5A5_5A5A);
    bus(1'h1, 7'h40, 32'hFFFF_FFFF);
    rdchk("unmapped", 7'h40, 32'h0);
    bus(1'h1, ADDR_VECTOR_PREFIX, 32'hABCD_1234);
    $display("registers test done");
  endtask

  task automatic test_xor;
    bus(1'h1, 7'h01, 32'h8000_00F0);
    bus(1'h1, 7'h02, 32'h0000_0FF0);
    bus(1'h1, ADDR_FIXED_EXC, 32'h1);
    issue({OP_EXTENDED, 5'h01, 5'h03, 5'h02, XO_XOR, 1'h1}, 32'h0);
    rdchk("xor result", 7'h03, 32'h8000_0F00);
    rdchk("xor cond neg", ADDR_COND, 32'h9);
    issue({OP_XOR_LOW, 5'h01, 5'h1F, 16'hFFFF}, 32'h0);
    rdchk("xor low", 7'h1F, 32'h8000_FF0F);
    issue({OP_XOR_SHIFT, 5'h01, 5'h1E, 16'hFFFF}, 32'h0);
    rdchk("xor shift", 7'h1E, 32'h7FFF_00F0);
    rdchk("imm cond kept", ADDR_COND, 32'h9);
    bus(1'h1, ADDR_FIXED_EXC, 32'h0);
    issue({OP_EXTENDED, 5'h01, 5'h03, 5'h01, XO_XOR, 1'h1}, 32'h0);
    rdchk("xor cond zero", ADDR_COND, 32'h2);
    issue({OP_EXTENDED, 5'h02, 5'h03, 5'h03, XO_XOR, 1'h1}, 32'h0);
    rdchk("xor cond pos", ADDR_COND, 32'h4);
    $display("xor test done");
  endtask

  task automatic test_enable;
    bus(1'h1, 7'h07, 32'h0000_8000);
    bus(1'h1, ADDR_MACHINE_STATE, 32'h0);
    issue({OP_EXTENDED, 5'h07, 10'h000, XO_IEN_REG, 1'h0}, 32'h0);
    rdchk("ien from reg", ADDR_MACHINE_STATE, 32'h0000_8000);
    bus(1'h1, 7'h07, 32'hFFFF_7FFF);
    issue({OP_EXTENDED, 5'h07, 10'h000, XO_IEN_REG, 1'h1}, 32'h0);
    rdchk("ien reg clear", ADDR_MACHINE_STATE, 32'h0);
    rdchk("ien cond kept", ADDR_COND, 32'h4);
    issue({OP_EXTENDED, 10'h000, 1'h1, 4'h0, XO_IEN_IMM, 1'h0}, 32'h0);
    rdchk("ien imm", ADDR_MACHINE_STATE, 32'h0000_8000);
    bus(1'h1, ADDR_MACHINE_STATE, 32'h0000_4000);
    issue({OP_EXTENDED, 10'h000, 1'h1, 4'h0, XO_IEN_IMM, 1'h0}, 32'h0);
    issue({OP_EXTENDED, 5'h07, 10'h000, XO_IEN_REG, 1'h0}, 32'h0);
    rdchk("ien problem", ADDR_MACHINE_STATE, 32'h0000_4000);
    $display("enable test done");
  endtask

  task automatic test_codes;
    bus(1'h1, ADDR_DEBUG_CONTROL, 32'h0);
    trap_case(5'h04, 32'h5, 16'h0005, 1'h1);
    trap_case(5'h04, 32'h5, 16'h0006, 1'h0);
    trap_case(5'h08, 32'hFFFF_FFFF, 16'hFFFE, 1'h1);
    trap_case(5'h10, 32'hFFFF_FFFF, 16'h0001, 1'h1);
    trap_case(5'h02, 32'hFFFF_FFFF, 16'h0001, 1'h0);
    trap_case(5'h01, 32'hFFFF_FFFF, 16'h0001, 1'h1);
    trap_case(5'h0C, 32'h3, 16'h0003, 1'h1);
    trap_case(5'h14, 32'h3, 16'h0002, 1'h0);
    trap_case(5'h18, 32'h3, 16'h0003, 1'h0);
    trap_case(5'h05, 32'h0, 16'hFFFF, 1'h0);
    trap_case(5'h06, 32'h0, 16'hFFFF, 1'h1);
    $display("condition codes test done");
  endtask

  task automatic test_routes;
    arm(32'h0006_C230, 32'h6, 32'h0000_2468);
    chk("prog vector", 32'hABCD_0700, seen_tgt);
    rdchk("prog addr", ADDR_SAVE_ZERO, 32'h0000_2468);
    rdchk("prog state", ADDR_SAVE_ONE, 32'h0006_C230);
    rdchk("prog syndrome", ADDR_SYNDROME, 32'h1);
    rdchk("prog new state", ADDR_MACHINE_STATE, 32'h0002_0200);
    arm(32'h0006_C030, 32'h5, 32'h0000_1358);
    chk("impr vector", 32'hABCD_0700, seen_tgt);
    rdchk("impr state", ADDR_SAVE_ONE, 32'h0006_C030);
    rdchk("impr status", ADDR_DEBUG_STATUS, 32'h3);
    rdchk("impr syndrome", ADDR_SYNDROME, 32'h1);
    rdchk("impr new state", ADDR_MACHINE_STATE, 32'h0002_0000);
    arm(32'h0006_C230, 32'h5, 32'h0000_5678);
    chk("dbg vector", 32'hABCD_2000, seen_tgt);
    rdchk("dbg addr", ADDR_SAVE_TWO, 32'h0000_5678);
    rdchk("dbg state", ADDR_SAVE_THREE, 32'h0006_C230);
    rdchk("dbg status", ADDR_DEBUG_STATUS, 32'h1);
    rdchk("dbg new state", ADDR_MACHINE_STATE, 32'h0);
    $display("trap routes test done");
  endtask

  task automatic test_external;
    arm(32'h0006_C230, 32'h3, 32'h0000_0ABC);
    chk("ext stop", 32'h1, {31'h0, seen_stop});
    chk("ext no load", 32'h0, {31'h0, seen_load});
    chk("ext ready", 32'h0, {31'h0, instr_ready});
    rdchk("ext status", ADDR_DEBUG_STATUS, 32'h1);
    rdchk("ext stopped", ADDR_CONTROL, 32'h1);
    bus(1'h1, ADDR_CONTROL, 32'h1);
    // Release lands on the edge the bus task returns at
    @(negedge ref_clk);
    chk("resumed", 32'h0, {31'h0, debug_stop});
    arm(32'h0006_C030, 32'h7, 32'h0000_3000);
    chk("ext impr load", 32'h1, {31'h0, seen_load});
    chk("ext impr addr", 32'h0000_3000, seen_tgt);
    rdchk("ext impr status", ADDR_DEBUG_STATUS, 32'h3);
    bus(1'h1, ADDR_CONTROL, 32'h1);
    $display("external debug test done");
  endtask

  // -------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    rst_n = 1'h0;
    instr_valid = 1'h0;
    instr_word = 32'h0;
    instr_addr = 32'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_address = '0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    test_regs;
    test_xor;
    test_enable;
    test_codes;
    test_routes;
    test_external;
    final_report;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    final_report;
  end
endmodule
